// File: core/lra_ol_pkg.sv
/*
 Package for the open-loop fallback and calibration timing block:
 register offsets, field positions, reset values, timing constants, carriers.
 Assumes a 100 MHz mclk and an 8-bit register port from the serial bus front end.
*/
package lraol_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	// Register offsets
	localparam logic [7:0] CAL_DUR_ADDR   = 8'h2A;
	localparam logic [7:0] FALLBACK_ADDR  = 8'h2C;
	localparam logic [7:0] PERIOD_HI_ADDR = 8'h2E;
	localparam logic [7:0] PERIOD_LO_ADDR = 8'h2F;
	// Reset values
	localparam logic [7:0] CAL_DUR_RST    = 8'h02;
	localparam logic [7:0] FALLBACK_RST   = 8'h00;
	localparam logic [7:0] PERIOD_HI_RST  = 8'h00;
	localparam logic [7:0] PERIOD_LO_RST  = 8'hC6;
	// Field positions
	localparam int unsigned FB_ENABLE_BIT  = 7;
	localparam int unsigned FB_COUNT_LSB   = 5;
	localparam int unsigned WAVE_SEL_BIT   = 0;
	// Calibration durations in ms per code
	localparam int unsigned CAL_MS_0 = 250;
	localparam int unsigned CAL_MS_1 = 500;
	localparam int unsigned CAL_MS_2 = 1000;
	localparam logic [1:0] CAL_CODE_TRIG = 2'h3;
	// Time base of the period unit: 24.615 us, held in ps
	localparam int unsigned PERIOD_UNIT_PS = 24_615_000;
	localparam int unsigned CLK_PERIOD_PS  = 1_000_000_000 / (CLK_HZ / 1000);
	localparam int unsigned PERIOD_UNIT_CYC = PERIOD_UNIT_PS / CLK_PERIOD_PS;
	// Fallback attempt base: code 0 means 3 attempts
	localparam logic [2:0] FB_ATTEMPT_BASE = 3'h3;
	// Measurement settle after every calibration, timed or trigger-cancelled, in us
	localparam int unsigned MEAS_US = 2000;

	typedef enum logic
	{
		LRAOL_SQUARE,
		LRAOL_SINE
	} lraol_wave_type;

	// Drive settings handed to the output stage
	typedef struct packed
	{
		logic           openLoop;
		lraol_wave_type wave;
		logic [9:0]     period;
	} lraol_drive_type;
endpackage

// File: core/lra_ol_period_timer.sv
/*
 Open-loop period timer: counts unit ticks and pulses at the end of each
 drive cycle. Assumes a one-cycle unit tick enable from the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module lraol_period_timer
#(
	parameter int unsigned WIDTH = 10
)
(
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic             unitTick,
	input  wire logic [WIDTH-1:0] period,
	output logic                  cycleEnd
);
	logic [WIDTH-1:0] count_q;

	// A one-bit counter cannot tell a period of one unit from a stopped timer
	if (WIDTH < 2)
	begin : g_badWidth
		$error("WIDTH too small");
	end

	// Counts units in the current drive cycle; a zero period never ends
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			count_q <= '0;
		else if (!run)
			count_q <= '0;
		else if (unitTick)
		begin
			if (count_q + WIDTH'(1) >= period)
				count_q <= '0;
			else
				count_q <= count_q + WIDTH'(1);
		end
	end

	assign cycleEnd = run && unitTick && (period != '0) && (count_q + WIDTH'(1) >= period);
endmodule // lraol_period_timer
`default_nettype wire

// File: core/lra_ol_fallback_cfg.sv
/*
 Calibration timing and open-loop fallback control of the haptic driver.
 Assumes an 8-bit register port from the serial bus front end, a zero-cross
 result strobe from the back-EMF logic, and trigger pulses from the sequencer.
*/
// Overview of operation
// - Codes 0..2 time calibration 250/500/1000 ms.
// - Code 3: start begins, trigger ends calibration.
// - After cancel trigger, measurements run, then done.
// - Enabled fallback switches open loop after failures.
// - Attempt code 0..3 means 3..6 failures.
// - Fallback drive is always square.
// - Open loop shape bit: 0 square, 1 sine.
// - Period is 10-bit setting times 24.615 us.
`timescale 1ns/1ns
`default_nettype none
module lraol_fallback_cfg
#(
	parameter int unsigned CAL_MS_0_CYC = lraol_pkg::CAL_MS_0 * (lraol_pkg::CLK_HZ / 1000),
	parameter int unsigned CAL_MS_1_CYC = lraol_pkg::CAL_MS_1 * (lraol_pkg::CLK_HZ / 1000),
	parameter int unsigned CAL_MS_2_CYC = lraol_pkg::CAL_MS_2 * (lraol_pkg::CLK_HZ / 1000),
	parameter int unsigned MEAS_CYC     = lraol_pkg::MEAS_US * (lraol_pkg::CLK_HZ / 1000000)
)
(
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      regWrite,
	input  wire logic [7:0]                regAddr,
	input  wire logic [7:0]                regWdata,
	output logic [7:0]                     regRdata,
	input  wire logic                      calStart,
	input  wire logic                      calTrigger,
	input  wire logic                      openLoopReq,
	input  wire logic                      driveActive,
	input  wire logic                      zeroCrossValid,
	input  wire logic                      zeroCrossFail,
	output logic                           calBusy,
	output logic                           calMeasure,
	output logic                           calDone,
	output lraol_pkg::lraol_drive_type     drive,
	output logic                           cycleEnd
);
	localparam int unsigned UNIT_CYC = lraol_pkg::PERIOD_UNIT_CYC;
	localparam int unsigned CNT_W = 32;

	typedef enum logic [1:0] {CAL_IDLE, CAL_TIMED, CAL_TRIG, CAL_MEAS} lraol_cal_type;

	logic [7:0]    calDur_q, fallback_q, periodHi_q, periodLo_q;
	logic          hiPending_q;
	logic [9:0]    period_q;
	logic [2:0]    failCount_q;
	logic          fellBack_q;
	lraol_cal_type calState_q;
	logic [CNT_W-1:0] calCount_q;
	logic [$clog2(UNIT_CYC+1)-1:0] unitCount_q;
	logic [CNT_W-1:0] calLimit;
	logic [2:0]    failLimit;
	logic          unitTick;
	logic          openLoop;
	logic [7:0]    calDurData;

	// A count that rounds to zero would stall the divider or the sequencer
	if (UNIT_CYC < 1 || MEAS_CYC < 1 ||
		CAL_MS_0_CYC < 1 || CAL_MS_1_CYC < 1 || CAL_MS_2_CYC < 1)
	begin : g_badTiming
		$error("Bad timing counts");
	end

	// Decode used by write and read paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Register writes; reserved bits stored as written
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			calDur_q    <= lraol_pkg::CAL_DUR_RST;
			fallback_q  <= lraol_pkg::FALLBACK_RST;
			periodHi_q  <= lraol_pkg::PERIOD_HI_RST;
			periodLo_q  <= lraol_pkg::PERIOD_LO_RST;
		end
		else if (regWrite)
		begin
			if (hit(regAddr, lraol_pkg::CAL_DUR_ADDR))
				calDur_q <= regWdata;
			if (hit(regAddr, lraol_pkg::FALLBACK_ADDR))
				fallback_q <= regWdata;
			if (hit(regAddr, lraol_pkg::PERIOD_HI_ADDR))
				periodHi_q <= regWdata;
			if (hit(regAddr, lraol_pkg::PERIOD_LO_ADDR))
				periodLo_q <= regWdata;
		end
	end

	// Upper byte alone is held back until the lower byte completes the pair
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hiPending_q <= 1'b0;
		else if (regWrite && hit(regAddr, lraol_pkg::PERIOD_HI_ADDR))
			hiPending_q <= 1'b1;
		else if (regWrite && hit(regAddr, lraol_pkg::PERIOD_LO_ADDR))
			hiPending_q <= 1'b0;
	end

	// Active period taken only at a cycle boundary or while not driving open loop
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			period_q <= {lraol_pkg::PERIOD_HI_RST[1:0], lraol_pkg::PERIOD_LO_RST};
		else if (!hiPending_q && (cycleEnd || !openLoop || !driveActive))
			period_q <= {periodHi_q[1:0], periodLo_q};
	end

	assign calDurData = calDur_q;

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		regRdata = 8'h00;
		if (hit(regAddr, lraol_pkg::CAL_DUR_ADDR))
			regRdata = calDurData;
		else if (hit(regAddr, lraol_pkg::FALLBACK_ADDR))
			regRdata = fallback_q;
		else if (hit(regAddr, lraol_pkg::PERIOD_HI_ADDR))
			regRdata = periodHi_q;
		else if (hit(regAddr, lraol_pkg::PERIOD_LO_ADDR))
			regRdata = periodLo_q;
	end

	// Duration per code
	always_comb
	begin
		unique case (calDur_q[1:0])
			2'h0: calLimit = CNT_W'(CAL_MS_0_CYC);
			2'h1: calLimit = CNT_W'(CAL_MS_1_CYC);
			2'h2: calLimit = CNT_W'(CAL_MS_2_CYC);
			2'h3: calLimit = '0;
		endcase
	end

	// Calibration sequence; trigger mode waits for the cancel trigger
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			calState_q <= CAL_IDLE;
			calCount_q <= '0;
		end
		else
		begin
			unique case (calState_q)
				CAL_IDLE:
					if (calStart)
					begin
						calCount_q <= '0;
						calState_q <= (calDur_q[1:0] == lraol_pkg::CAL_CODE_TRIG) ?
							CAL_TRIG : CAL_TIMED;
					end
				CAL_TIMED:
					if (calCount_q + CNT_W'(1) >= calLimit)
					begin
						calCount_q <= '0;
						calState_q <= CAL_MEAS;
					end
					else
						calCount_q <= calCount_q + CNT_W'(1);
				CAL_TRIG:
					// Early cancel is the host's risk: length is not policed here
					if (calTrigger)
					begin
						calCount_q <= '0;
						calState_q <= CAL_MEAS;
					end
				CAL_MEAS:
					if (calCount_q + CNT_W'(1) >= CNT_W'(MEAS_CYC))
					begin
						calCount_q <= '0;
						calState_q <= CAL_IDLE;
					end
					else
						calCount_q <= calCount_q + CNT_W'(1);
			endcase
		end
	end

	// Done pulse marks the end of the measurement step
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			calDone <= 1'b0;
		else
			calDone <= (calState_q == CAL_MEAS) &&
				(calCount_q + CNT_W'(1) >= CNT_W'(MEAS_CYC));
	end

	assign calBusy    = calState_q != CAL_IDLE;
	assign calMeasure = calState_q == CAL_MEAS;

	// Attempt code maps to 3..6 consecutive failures
	assign failLimit = lraol_pkg::FB_ATTEMPT_BASE +
		{1'b0, fallback_q[lraol_pkg::FB_COUNT_LSB +: 2]};

	// Consecutive failure counter; a good crossing restarts the count
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			failCount_q <= '0;
			fellBack_q  <= 1'b0;
		end
		else if (!driveActive || !fallback_q[lraol_pkg::FB_ENABLE_BIT])
		begin
			failCount_q <= '0;
			fellBack_q  <= 1'b0;
		end
		else if (zeroCrossValid)
			failCount_q <= '0;
		else if (zeroCrossFail && !fellBack_q)
		begin
			if (failCount_q + 3'h1 >= failLimit)
				fellBack_q <= 1'b1;
			failCount_q <= failCount_q + 3'h1;
		end
	end

	// Unit tick divider for the 24.615 us period base
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			unitCount_q <= '0;
		else if (unitTick)
			unitCount_q <= '0;
		else
			unitCount_q <= unitCount_q + 1'b1;
	end

	assign unitTick = unitCount_q == ($bits(unitCount_q))'(UNIT_CYC - 1);
	assign openLoop = openLoopReq || fellBack_q;

	lraol_period_timer #(.WIDTH(10)) periodTimer
	(
		.mclk     (mclk),
		.rst      (rst),
		.run      (openLoop && driveActive),
		.unitTick (unitTick),
		.period   (period_q),
		.cycleEnd (cycleEnd)
	);

	// Drive selection: fallback forces square, else the shape bit
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			drive <= '{openLoop: 1'b0, wave: lraol_pkg::LRAOL_SQUARE,
				period: {lraol_pkg::PERIOD_HI_RST[1:0], lraol_pkg::PERIOD_LO_RST}};
		else
		begin
			drive.openLoop <= openLoop;
			drive.period   <= period_q;
			if (fellBack_q)
				drive.wave <= lraol_pkg::LRAOL_SQUARE;
			else
				drive.wave <= lraol_pkg::lraol_wave_type'(
					fallback_q[lraol_pkg::WAVE_SEL_BIT]);
		end
	end
endmodule // lraol_fallback_cfg
`default_nettype wire

// File: bench/lraol_monitor.sv
/* Checker on the ports of the fallback and calibration block.
 Assumes one clock domain and the async high reset. */
`timescale 1ns/1ns
`default_nettype none
module lraol_monitor
(
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic [7:0]                 regAddr,
	input  wire logic [7:0]                 regRdata,
	input  wire logic                       calStart,
	input  wire logic                       openLoopReq,
	input  wire logic                       driveActive,
	input  wire logic                       calBusy,
	input  wire logic                       calMeasure,
	input  wire logic                       calDone,
	input  wire lraol_pkg::lraol_drive_type drive,
	input  wire logic                       cycleEnd
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Calibration sequencing
	property p_start; $rose(calBusy) |-> $past(calStart); endproperty
	a_start: assert property (p_start) else $error("busy without start");
	property p_meas; calMeasure |-> calBusy; endproperty
	a_meas: assert property (p_meas) else $error("measure outside run");
	property p_done; calDone |-> !calBusy && $past(calMeasure); endproperty
	a_done: assert property (p_done) else $error("done not after measure");
	property p_pulse; calDone |=> !calDone; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	// Fallback drive is square whatever the shape bit says
	property p_square;
		drive.openLoop && !openLoopReq && !$past(openLoopReq) |-> drive.wave == lraol_pkg::LRAOL_SQUARE;
	endproperty
	a_square: assert property (p_square) else $error("fallback not square");
	property p_end; cycleEnd |-> drive.period != 10'h000; endproperty
	a_end: assert property (p_end) else $error("cycle end on zero period");
	// Period may only move at a cycle boundary while driving open loop
	property p_hold;
		$past(drive.openLoop) && $past(driveActive, 2) && $changed(drive.period)
			|-> $past(cycleEnd, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("period changed mid cycle");
	property p_unmap;
		!(regAddr inside {8'h2A, 8'h2C, 8'h2E, 8'h2F}) |-> regRdata == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	c_done: cover property (calDone);
	c_end: cover property (cycleEnd);
	c_fall: cover property (drive.openLoop && !openLoopReq);
endmodule // lraol_monitor
bind lraol_fallback_cfg lraol_monitor mon (.mclk, .rst, .regAddr, .regRdata, .calStart,
	.openLoopReq, .driveActive, .calBusy, .calMeasure, .calDone, .drive, .cycleEnd);
`default_nettype wire

// File: bench/lraol_actuator_model.sv
/* Actuator stand-in: one zero-cross result every 8 cycles in closed loop.
 Assumes the bench raises bad to make every detection fail. */
`timescale 1ns/1ns
`default_nettype none
module lraol_actuator_model
(
	input  wire logic mclk,
	input  wire logic driveActive,
	input  wire logic openLoop,
	input  wire logic bad,
	output logic      zcValid,
	output logic      zcFail
);
	logic [2:0] tick_q = 3'h0;
	// Back-EMF gives no result once the drive runs open loop
	always_ff @(posedge mclk)
	begin
		tick_q <= tick_q + 3'h1;
		zcValid <= driveActive && !openLoop && tick_q == 3'h7 && !bad;
		zcFail <= driveActive && !openLoop && tick_q == 3'h7 && bad;
	end
endmodule // lraol_actuator_model
`default_nettype wire

// File: bench/lraol_fallback_cfg_test.sv
/* Self-checking bench of the fallback and calibration block.
 Assumes shortened calibration counts (250/500/1000, measure 20). */
`timescale 1ns/1ns
`default_nettype none
module lraol_fallback_cfg_test;
	logic mclk = 0, rst, regWrite, calStart, calTrigger, openLoopReq, driveActive, bad;
	logic [7:0] regAddr, regWdata, regRdata;
	logic calBusy, calMeasure, calDone, cycleEnd, zcValid, zcFail;
	lraol_pkg::lraol_drive_type drv;
	int failures = 0, n_tests = 0, seed = 19342, t, u;
	int m[int];
	lraol_fallback_cfg #(.CAL_MS_0_CYC(250), .CAL_MS_1_CYC(500), .CAL_MS_2_CYC(1000),
		.MEAS_CYC(20)) DUT (.mclk, .rst, .regWrite, .regAddr, .regWdata, .regRdata, .calStart,
		.calTrigger, .openLoopReq, .driveActive, .zeroCrossValid(zcValid),
		.zeroCrossFail(zcFail), .calBusy, .calMeasure, .calDone, .drive(drv), .cycleEnd);
	lraol_actuator_model act (.mclk, .driveActive, .openLoop(drv.openLoop), .bad, .zcValid,
		.zcFail);
	always #5 mclk = ~mclk;
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	// Register write; the model follows every mapped write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrite <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge mclk);
		regWrite <= 0;
		if (m.exists(a)) m[a] = d;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		@(negedge mclk);
		chk(regRdata, m.exists(a) ? m[a] : 0);
	endtask
	// One calibration; code 3 runs until the bench cancels it
	task cal(input int c);
		wr(8'h2A, 8'(c));
		calStart <= 1;
		@(posedge mclk);
		calStart <= 0;
		if (c == 3)
		begin
			repeat (1500) @(posedge mclk);
			chk(calBusy, 1);
			calTrigger <= 1;
			@(posedge mclk);
			calTrigger <= 0;
		end
		t = 0;
		u = 0;
		while (!calDone && u < 3000)
		begin
			@(negedge mclk);
			t += calMeasure;
			u += calBusy;
		end
		chk(t, 20);
		if (c < 3) chk(u, (250 << c) + 20);
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Cuts a hang short well past the expected run length
	initial
	begin
		#1_000_000;
		failures++;
		close_out;
	end
	initial
	begin
		{rst, regWrite, calStart, calTrigger, openLoopReq, driveActive, bad} = 7'h40;
		{regAddr, regWdata} = 16'h0000;
		m[8'h2A] = 2;
		m[8'h2C] = 0;
		m[8'h2E] = 0;
		m[8'h2F] = 8'hC6;
		repeat (4) @(posedge mclk);
		rst <= 0;
		for (int a = 8'h29; a < 8'h31; a++) rd(8'(a));
		for (int a = 8'h29; a < 8'h31; a++)
		begin
			wr(8'(a), 8'($random(seed)));
			rd(8'(a));
		end
		$display("registers done");
		for (int c = 0; c < 4; c++) cal(c);
		$display("calibration done");
		// Fallback at each attempt count, shape bit set to sine
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h2C, 8'(8'h81 | c << 5));
			driveActive <= 1;
			bad <= 1;
			t = 0;
			u = 0;
			while (!drv.openLoop && u++ < 300)
			begin
				@(negedge mclk);
				t += zcFail;
			end
			chk(t, 3 + c);
			chk(drv.wave, lraol_pkg::LRAOL_SQUARE);
			@(posedge mclk);
			driveActive <= 0;
			repeat (3) @(posedge mclk);
		end
		wr(8'h2C, 8'h60);
		driveActive <= 1;
		repeat (100) @(posedge mclk);
		chk(drv.openLoop, 0);
		driveActive <= 0;
		bad <= 0;
		$display("fallback done");
		wr(8'h2E, 8'h00);
		wr(8'h2F, 8'h02);
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h2C, 8'(s));
			openLoopReq <= 1;
			driveActive <= 1;
			repeat (3) @(negedge mclk);
			chk(drv.wave, 12'(s));
			chk(drv.period, 12'h002);
		end
		// Upper byte alone must not reach the drive
		wr(8'h2E, 8'h01);
		repeat (3) @(negedge mclk);
		chk(drv.period, 12'h002);
		@(negedge cycleEnd);
		t = 0;
		while (!cycleEnd && t < 6000)
		begin
			@(negedge mclk);
			t++;
		end
		chk(t, 2 * 2461);
		wr(8'h2F, 8'h00);
		@(negedge cycleEnd);
		repeat (3) @(negedge mclk);
		chk(drv.period, 12'h100);
		$display("open loop done");
		close_out;
	end
endmodule // lraol_fallback_cfg_test
`default_nettype wire
